// ==== common/dchn_pkg.sv ====
package dchn_pkg;

    // ----------------------------------------------------------------
    // Message layout and field codes
    // ----------------------------------------------------------------
    localparam int MSG_BITS = 64;
    localparam logic [7:0] MSG_BITS_CNT = 8'h40;
    localparam logic [5:0] NODE_ADDR_RESET = 6'h00;
    localparam logic [5:0] TARGET_ALL = 6'h3F;
    localparam logic [15:0] WAKE_WORD = 16'hFFEE;
    localparam logic [1:0] CMD_NOP = 2'h0;
    localparam logic [1:0] CMD_READ = 2'h1;
    localparam logic [1:0] CMD_WRITE = 2'h2;
    localparam logic [1:0] CMD_RESPONSE = 2'h3;
    localparam logic [13:0] ADDR_ASSIGN_REG = 14'h0001;

    // ----------------------------------------------------------------
    // Message sources and timing defaults in core clock cycles
    // ----------------------------------------------------------------
    localparam logic [1:0] SRC_PORT0 = 2'h0;
    localparam logic [1:0] SRC_PORT1 = 2'h1;
    localparam logic [1:0] SRC_SPI = 2'h2;
    localparam int unsigned FWD_STEP_CYCLES_DEF = 100;
    localparam int unsigned WAKE_GAP_CYCLES_DEF = 1000;

    typedef struct packed {
        logic [1:0] cmd;
        logic direction_flag;
        logic [2:0] chain_id_field;
        logic [5:0] target_node_field;
        logic [3:0] counter;
        logic [1:0] data_len;
        logic [13:0] reg_addr;
        logic [15:0] data;
        logic [15:0] crc;
    } dchn_msg_type;

    // Wake message this node generates; CRC is filled in by the symbol layer
    localparam dchn_msg_type WAKE_MSG = '{
        cmd: 2'h0, direction_flag: 1'h0, chain_id_field: 3'h7,
        target_node_field: 6'h3F, counter: 4'hF, data_len: 2'h3,
        reg_addr: 14'h3FFF, data: 16'hFFEE, crc: 16'h0000};

endpackage : dchn_pkg

// ==== design/dchn_bcast_delay.sv ====
`timescale 1ns/1ps
module dchn_bcast_delay #(
    parameter int unsigned STEP_CYCLES = dchn_pkg::FWD_STEP_CYCLES_DEF
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_start,
    input wire logic [5:0] i_steps,
    output logic o_busy,
    output logic o_done
);
    import dchn_pkg::*;

    if (STEP_CYCLES < 1 || STEP_CYCLES > 65535) begin : g_chk
        $error("STEP_CYCLES out of range");
    end

    logic [5:0] steps_left;
    logic [15:0] cyc;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_busy <= 1'b0;
            o_done <= 1'b0;
            steps_left <= 6'h00;
            cyc <= 16'h0000;
        end else begin
            o_done <= 1'b0;
            if (i_start) begin
                o_busy <= 1'b1;
                steps_left <= i_steps;
                cyc <= 16'(STEP_CYCLES - 1);
            end else if (o_busy) begin
                if (steps_left == 6'h00) begin
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                end else if (cyc == 16'h0000) begin
                    steps_left <= steps_left - 6'h01;
                    cyc <= 16'(STEP_CYCLES - 1);
                end else begin
                    cyc <= cyc - 16'h0001;
                end
            end
        end
    end

endmodule : dchn_bcast_delay

// ==== design/dchn_spi_follower.sv ====
`timescale 1ns/1ps
module dchn_spi_follower (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_select_or_rx_low_pin_n,
    input wire logic i_shift_clock_pin,
    input wire logic i_serial_in_pin,
    output logic o_serial_out,
    output logic o_msg_valid,
    output dchn_pkg::dchn_msg_type o_msg,
    input wire logic i_resp_load,
    input dchn_pkg::dchn_msg_type i_resp_msg,
    output logic o_resp_frame_error
);
    import dchn_pkg::*;

    logic cs_q;
    logic sck_q;
    logic [MSG_BITS-1:0] in_sh;
    logic [MSG_BITS-1:0] out_sh;
    logic [MSG_BITS-1:0] out_next;
    logic [7:0] bit_cnt;
    logic had_resp;
    logic next_has_resp;

    assign o_serial_out = out_sh[MSG_BITS-1];

    // ----------------------------------------------------------------
    // Shifting: change on rising clock, sample on falling, MSB first
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cs_q <= 1'b1;
            sck_q <= 1'b0;
            in_sh <= '0;
            out_sh <= '0;
            bit_cnt <= 8'h00;
            had_resp <= 1'b0;
        end else begin
            cs_q <= i_select_or_rx_low_pin_n;
            sck_q <= i_shift_clock_pin;
            if (cs_q && !i_select_or_rx_low_pin_n) begin
                out_sh <= out_next;
                had_resp <= next_has_resp;
                bit_cnt <= 8'h00;
            end else if (!i_select_or_rx_low_pin_n) begin
                if (!sck_q && i_shift_clock_pin && bit_cnt != 8'h00) begin
                    out_sh <= {out_sh[MSG_BITS-2:0], 1'b0};
                end
                if (sck_q && !i_shift_clock_pin) begin
                    in_sh <= {in_sh[MSG_BITS-2:0], i_serial_in_pin};
                    if (bit_cnt != 8'hFF) begin
                        bit_cnt <= bit_cnt + 8'h01;
                    end
                end
            end
        end
    end

    // Response waiting for the next frame; a frame with nothing loaded sends zeros
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            out_next <= '0;
            next_has_resp <= 1'b0;
        end else if (i_resp_load) begin
            out_next <= i_resp_msg;
            next_has_resp <= 1'b1;
        end else if (cs_q && !i_select_or_rx_low_pin_n) begin
            out_next <= '0;
            next_has_resp <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Decode on chip select rising
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_msg_valid <= 1'b0;
            o_msg <= '0;
            o_resp_frame_error <= 1'b0;
        end else begin
            o_msg_valid <= 1'b0;
            o_resp_frame_error <= 1'b0;
            if (!cs_q && i_select_or_rx_low_pin_n) begin
                if (had_resp && bit_cnt != MSG_BITS_CNT) begin
                    o_resp_frame_error <= 1'b1;
                end else if (bit_cnt >= MSG_BITS_CNT) begin
                    o_msg_valid <= 1'b1;
                    o_msg <= in_sh;
                end
            end
        end
    end

endmodule : dchn_spi_follower

// ==== design/dchn_node.sv ====
`timescale 1ns/1ps
module dchn_node #(
    parameter int unsigned FWD_STEP_CYCLES = dchn_pkg::FWD_STEP_CYCLES_DEF,
    parameter int unsigned WAKE_GAP_CYCLES = dchn_pkg::WAKE_GAP_CYCLES_DEF
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_deep_sleep,
    input wire logic i_bus_activity,
    input wire logic i_bus_busy,
    input wire logic [5:0] i_chain_node_count,
    input wire logic i_relay_enable,
    input wire logic [1:0] i_rx_valid,
    input wire logic [1:0] i_rx_ok,
    input dchn_pkg::dchn_msg_type [1:0] i_rx_msg,
    output logic [1:0] o_relay_valid,
    output dchn_pkg::dchn_msg_type [1:0] o_relay_msg,
    output logic [1:0] o_tx_valid,
    output dchn_pkg::dchn_msg_type o_tx_msg,
    input wire logic [1:0] i_tx_ready,
    output logic [13:0] o_reg_rd_addr,
    input wire logic [15:0] i_reg_rd_data,
    output logic o_exec_valid,
    output logic [13:0] o_exec_addr,
    output logic [15:0] o_exec_data,
    output logic [5:0] o_own_node_address,
    output logic o_active,
    input wire logic i_select_or_rx_low_pin_n,
    input wire logic i_shift_clock_pin,
    input wire logic i_serial_in_pin,
    output logic o_serial_out,
    output logic o_resp_frame_error
);
    import dchn_pkg::*;

    if (WAKE_GAP_CYCLES < 1 || WAKE_GAP_CYCLES > 65535) begin : g_chk
        $error("WAKE_GAP_CYCLES out of range");
    end

    typedef enum logic [1:0] {WK_IDLE, WK_GAP, WK_DONE} dchn_wake_type;

    function automatic logic [5:0] bcast_steps(input logic dir, input logic [5:0] cnt,
                                               input logic [5:0] adr);
        if (dir) begin
            bcast_steps = (adr == 6'h00) ? 6'h00 : adr - 6'h01;
        end else begin
            bcast_steps = (cnt >= adr) ? cnt - adr : 6'h00;
        end
    endfunction : bcast_steps

    // ----------------------------------------------------------------
    // Receive selection and decode
    // ----------------------------------------------------------------
    logic spi_valid;
    dchn_msg_type spi_msg;
    logic rx_any;
    dchn_msg_type rx_msg;
    logic [1:0] rx_src;

    always_comb begin
        rx_any = 1'b0;
        rx_msg = spi_msg;
        rx_src = SRC_SPI;
        if (i_rx_valid[0] && i_rx_ok[0]) begin
            rx_any = 1'b1;
            rx_msg = i_rx_msg[0];
            rx_src = SRC_PORT0;
        end else if (i_rx_valid[1] && i_rx_ok[1]) begin
            rx_any = 1'b1;
            rx_msg = i_rx_msg[1];
            rx_src = SRC_PORT1;
        end else if (spi_valid) begin
            rx_any = 1'b1;
        end
    end

    logic [7:0] resp_rem;
    logic resp_spi;
    logic bc_busy;
    logic bc_done;
    logic is_bcast;
    logic for_me;
    logic is_wake;
    logic from_spi;
    logic ignore_rx;
    logic accept;
    logic wr_now;
    logic bc_start;
    logic rd_start;

    assign is_bcast = rx_msg.target_node_field == TARGET_ALL;
    assign for_me = is_bcast || rx_msg.target_node_field == o_own_node_address;
    assign is_wake = rx_msg.cmd == CMD_NOP && is_bcast && rx_msg.data == WAKE_WORD;
    assign from_spi = rx_src == SRC_SPI;
    assign ignore_rx = !from_spi && ((resp_rem != 8'h00 && !resp_spi) || bc_busy);
    assign accept = rx_any && for_me && !ignore_rx;
    assign wr_now = accept && rx_msg.cmd == CMD_WRITE && !is_bcast;
    assign bc_start = accept && rx_msg.cmd == CMD_WRITE && is_bcast;
    assign rd_start = accept && rx_msg.cmd == CMD_READ && !is_bcast;

    // ----------------------------------------------------------------
    // Own address and activity
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_own_node_address <= NODE_ADDR_RESET;
        end else if (i_deep_sleep) begin
            o_own_node_address <= NODE_ADDR_RESET;
        end else if (wr_now && rx_msg.reg_addr == ADDR_ASSIGN_REG) begin
            o_own_node_address <= rx_msg.data[5:0];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_active <= 1'b0;
        end else if (i_deep_sleep) begin
            o_active <= 1'b0;
        end else if (i_bus_activity || |i_rx_valid) begin
            o_active <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Relay between the two chain ports
    // ----------------------------------------------------------------
    logic relay_on;
    assign relay_on = o_own_node_address != NODE_ADDR_RESET && i_relay_enable;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_relay_valid <= 2'b00;
            o_relay_msg <= '0;
        end else begin
            o_relay_valid <= {i_rx_valid[0], i_rx_valid[1]} & {2{relay_on}};
            o_relay_msg <= {i_rx_msg[0], i_rx_msg[1]};
        end
    end

    // ----------------------------------------------------------------
    // Write execution, broadcast writes wait out the forward delay
    // ----------------------------------------------------------------
    logic [13:0] bc_addr;
    logic [15:0] bc_data;

    dchn_bcast_delay #(
        .STEP_CYCLES(FWD_STEP_CYCLES)
    ) u_delay (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_start(bc_start),
        .i_steps(bcast_steps(rx_msg.direction_flag, i_chain_node_count,
                             o_own_node_address)),
        .o_busy(bc_busy),
        .o_done(bc_done)
    );

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bc_addr <= 14'h0000;
            bc_data <= 16'h0000;
        end else if (bc_start) begin
            bc_addr <= rx_msg.reg_addr;
            bc_data <= rx_msg.data;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_exec_valid <= 1'b0;
            o_exec_addr <= 14'h0000;
            o_exec_data <= 16'h0000;
        end else begin
            o_exec_valid <= wr_now || bc_done;
            if (wr_now) begin
                o_exec_addr <= rx_msg.reg_addr;
                o_exec_data <= rx_msg.data;
            end else if (bc_done) begin
                o_exec_addr <= bc_addr;
                o_exec_data <= bc_data;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read responses
    // ----------------------------------------------------------------
    logic [13:0] resp_addr;
    logic resp_dir;
    logic [2:0] resp_chain;
    logic spi_due;
    logic send_chain;
    logic send_spi;
    logic wake_send;
    dchn_msg_type resp_msg;

    assign o_reg_rd_addr = resp_addr;
    assign send_chain = resp_rem != 8'h00 && !resp_spi && o_tx_valid == 2'b00
                        && !i_bus_busy;
    assign send_spi = resp_rem != 8'h00 && resp_spi && spi_due;

    always_comb begin
        resp_msg = '0;
        resp_msg.cmd = CMD_RESPONSE;
        resp_msg.direction_flag = resp_dir;
        resp_msg.chain_id_field = resp_chain;
        resp_msg.target_node_field = o_own_node_address;
        resp_msg.reg_addr = resp_addr;
        resp_msg.data = i_reg_rd_data;
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            resp_rem <= 8'h00;
            resp_addr <= 14'h0000;
            resp_dir <= 1'b0;
            resp_chain <= 3'h0;
            resp_spi <= 1'b0;
        end else if (rd_start) begin
            resp_rem <= (rx_msg.data[7:0] == 8'h00) ? 8'h01 : rx_msg.data[7:0];
            resp_addr <= rx_msg.reg_addr;
            resp_dir <= rx_msg.direction_flag;
            resp_chain <= rx_msg.chain_id_field;
            resp_spi <= from_spi;
        end else if (accept && from_spi && resp_spi && rx_msg.cmd != CMD_NOP) begin
            resp_rem <= 8'h00;
        end else if (send_chain || send_spi) begin
            resp_rem <= resp_rem - 8'h01;
            resp_addr <= resp_addr + 14'h0001;
        end
    end

    // A NOP frame pulls the next pending word into the following frame
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            spi_due <= 1'b0;
        end else if ((rd_start && from_spi) || (accept && from_spi && rx_msg.cmd == CMD_NOP)) begin
            spi_due <= 1'b1;
        end else if (send_spi || (accept && from_spi)) begin
            spi_due <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Chain transmit: responses on both ports, wake on the far port
    // ----------------------------------------------------------------
    logic [1:0] gen_port;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_tx_valid <= 2'b00;
            o_tx_msg <= '0;
        end else if (send_chain) begin
            o_tx_valid <= 2'b11;
            o_tx_msg <= resp_msg;
        end else if (wake_send) begin
            o_tx_valid <= gen_port;
            o_tx_msg <= WAKE_MSG;
        end else begin
            o_tx_valid <= o_tx_valid & ~i_tx_ready;
        end
    end

    // ----------------------------------------------------------------
    // Wake sequence
    // ----------------------------------------------------------------
    dchn_wake_type wk_state;
    logic [1:0] wake_cnt;
    logic [1:0] gen_left;
    logic [15:0] gap_cnt;
    logic wake_in;

    assign wake_in = rx_any && is_wake && !from_spi;
    assign wake_send = wk_state == WK_GAP && gap_cnt == 16'h0000 && o_tx_valid == 2'b00
                       && !send_chain;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wk_state <= WK_IDLE;
            wake_cnt <= 2'h0;
            gen_left <= 2'h0;
            gap_cnt <= 16'h0000;
            gen_port <= 2'b00;
        end else if (i_deep_sleep) begin
            wk_state <= WK_IDLE;
            wake_cnt <= 2'h0;
            gen_left <= 2'h0;
        end else begin
            case (wk_state)
                WK_IDLE: begin
                    if (wake_in) begin
                        wake_cnt <= wake_cnt + 2'h1;
                        if (wake_cnt == 2'h1) begin
                            wk_state <= WK_GAP;
                            gen_left <= relay_on ? 2'h1 : 2'h2;
                            gap_cnt <= 16'(WAKE_GAP_CYCLES - 1);
                            gen_port <= (rx_src == SRC_PORT0) ? 2'b10 : 2'b01;
                        end
                    end
                end
                WK_GAP: begin
                    if (rx_any && gap_cnt != 16'h0000) begin
                        wk_state <= WK_DONE;
                        gen_left <= 2'h0;
                    end else if (wake_send) begin
                        gen_left <= gen_left - 2'h1;
                        gap_cnt <= 16'(WAKE_GAP_CYCLES - 1);
                        if (gen_left == 2'h1) begin
                            wk_state <= WK_DONE;
                        end
                    end else if (gap_cnt != 16'h0000) begin
                        gap_cnt <= gap_cnt - 16'h0001;
                    end
                end
                WK_DONE: begin
                    wk_state <= WK_DONE;
                end
                default: begin
                    wk_state <= WK_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // SPI follower port
    // ----------------------------------------------------------------
    dchn_spi_follower u_spi (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_select_or_rx_low_pin_n(i_select_or_rx_low_pin_n),
        .i_shift_clock_pin(i_shift_clock_pin),
        .i_serial_in_pin(i_serial_in_pin),
        .o_serial_out(o_serial_out),
        .o_msg_valid(spi_valid),
        .o_msg(spi_msg),
        .i_resp_load(send_spi),
        .i_resp_msg(resp_msg),
        .o_resp_frame_error(o_resp_frame_error)
    );

endmodule : dchn_node

// ==== tb/dchn_leader_model.sv ====
`timescale 1ns/1ps
module dchn_leader_model (
    input wire logic i_clk_sys,
    input wire logic [1:0] i_tx_valid,
    input wire logic i_slow,
    output logic [1:0] o_tx_ready
);
    int wait_cnt[2] = '{0, 0};
    initial o_tx_ready = 2'h0;
    // Leader paces its own acceptance, so responses never collide
    always @(negedge i_clk_sys) begin
        for (int p = 0; p < 2; p++) begin
            if (o_tx_ready[p] || !i_tx_valid[p]) begin
                o_tx_ready[p] <= 1'b0;
                wait_cnt[p] <= i_slow ? 2 + p : 0;
            end else if (wait_cnt[p] > 0) begin
                wait_cnt[p] <= wait_cnt[p] - 1;
            end else begin
                o_tx_ready[p] <= 1'b1;
            end
        end
    end
endmodule : dchn_leader_model

// ==== tb/dchn_node_assertions.sv ====
`timescale 1ns/1ps
module dchn_node_checker
    import dchn_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_deep_sleep,
    input wire logic i_bus_activity,
    input wire logic i_bus_busy,
    input wire logic i_relay_enable,
    input wire logic [1:0] i_rx_valid,
    input wire logic [1:0] i_rx_ok,
    input dchn_pkg::dchn_msg_type [1:0] i_rx_msg,
    input wire logic [1:0] o_relay_valid,
    input dchn_pkg::dchn_msg_type [1:0] o_relay_msg,
    input wire logic [1:0] o_tx_valid,
    input dchn_pkg::dchn_msg_type o_tx_msg,
    input wire logic o_exec_valid,
    input wire logic [13:0] o_exec_addr,
    input wire logic [15:0] o_exec_data,
    input wire logic [5:0] o_own_node_address,
    input wire logic o_active
);
    logic rx0;
    logic rsp;
    assign rx0 = i_rx_valid[0] & i_rx_ok[0];
    assign rsp = o_tx_msg.cmd == CMD_RESPONSE;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    relay_down_a: assert property (i_rx_valid[0] && o_own_node_address != 6'h00
        && i_relay_enable |=> o_relay_valid[1] && o_relay_msg[1] == $past(i_rx_msg[0]))
        else $error("relay missing");
    quiet_unenum_a: assert property (o_own_node_address == 6'h00 |=> o_relay_valid == 2'h0)
        else $error("relay while unenumerated");
    both_ports_a: assert property ($rose(|o_tx_valid) && rsp |-> o_tx_valid == 2'h3)
        else $error("response not on both ports");
    busy_hold_a: assert property ($rose(|o_tx_valid) && rsp |-> !$past(i_bus_busy))
        else $error("response started while busy");
    resp_fields_a: assert property (o_tx_valid == 2'h3 |-> rsp
        && o_tx_msg.target_node_field == o_own_node_address) else $error("bad response header");
    own_write_a: assert property (rx0 && i_rx_msg[0].cmd == CMD_WRITE && o_tx_valid == 2'h0
        && i_rx_msg[0].target_node_field == o_own_node_address |=> o_exec_valid
        && o_exec_addr == $past(i_rx_msg[0].reg_addr) && o_exec_data == $past(i_rx_msg[0].data))
        else $error("own write not executed");
    foreign_a: assert property (rx0 && i_rx_msg[0].target_node_field != o_own_node_address
        && i_rx_msg[0].target_node_field != TARGET_ALL |=> !o_exec_valid)
        else $error("foreign message executed");
    wake_active_a: assert property (i_bus_activity && !i_deep_sleep |=> o_active)
        else $error("activity did not wake node");
endmodule : dchn_node_checker

bind dchn_node dchn_node_checker u_chk (.i_clk_sys, .i_reset_n, .i_deep_sleep, .i_bus_activity,
    .i_bus_busy, .i_relay_enable, .i_rx_valid, .i_rx_ok, .i_rx_msg, .o_relay_valid, .o_relay_msg,
    .o_tx_valid, .o_tx_msg, .o_exec_valid, .o_exec_addr, .o_exec_data, .o_own_node_address,
    .o_active);

// ==== tb/test_daisy_chain_host_comm_node.sv ====
`timescale 1ns/1ps
module test_daisy_chain_host_comm_node;
    import dchn_pkg::*;
    localparam int STEP = 2;
    logic i_clk_sys, i_reset_n, i_deep_sleep, i_bus_activity, i_bus_busy, i_relay_enable, slow;
    logic o_exec_valid, o_active, o_serial_out, o_resp_frame_error, cs_n, sck, mosi;
    logic [5:0] i_chain_node_count, o_own_node_address;
    logic [1:0] i_rx_valid, i_rx_ok, o_relay_valid, o_tx_valid, i_tx_ready;
    dchn_msg_type [1:0] i_rx_msg, o_relay_msg;
    dchn_msg_type o_tx_msg;
    logic [13:0] o_reg_rd_addr, o_exec_addr, a;
    logic [15:0] i_reg_rd_data, o_exec_data, dat;
    int errors = 0, cmp_count = 0, cyc = 0, seed = 3, d;
    int steps[3] = '{3, 4, 0};
    logic dirs[3] = '{1'b0, 1'b1, 1'b0};
    logic [5:0] cnts[3] = '{6'h08, 6'h08, 6'h02};
    logic [63:0] exec_q[$];
    logic [56:0] tx_q[$];

    // Register file stand-in: reply derived from the address
    assign i_reg_rd_data = {2'h0, o_reg_rd_addr} ^ 16'h5A5A;

    dchn_node #(.FWD_STEP_CYCLES(STEP), .WAKE_GAP_CYCLES(4)) DUT (.*,
        .i_select_or_rx_low_pin_n(cs_n), .i_shift_clock_pin(sck), .i_serial_in_pin(mosi));
    dchn_leader_model leader (.i_clk_sys, .i_tx_valid(o_tx_valid), .i_slow(slow),
        .o_tx_ready(i_tx_ready));

    initial begin
        i_clk_sys = 1'b0;
        forever #4 i_clk_sys = ~i_clk_sys;
    end

    function automatic logic [56:0] pj(input dchn_msg_type m);
        return {m.cmd, m.chain_id_field, m.target_node_field, m.reg_addr, m.data, m.crc};
    endfunction : pj

    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    task automatic send(input int p, input logic [1:0] cmd, input logic dir, input logic [5:0] tgt,
                        input logic [13:0] ra, input logic [15:0] dv);
        @(negedge i_clk_sys);
        d = cyc;
        i_rx_msg[p] = {cmd, dir, 3'h5, tgt, 4'h0, 2'h0, ra, dv, 16'h0000};
        i_rx_valid[p] = 1'b1;
        i_rx_ok[p] = 1'b1;
        @(negedge i_clk_sys);
        i_rx_valid = 2'h0;
        i_rx_msg[p] = ~i_rx_msg[p];
    endtask : send

    task automatic spi(input logic [63:0] w, input logic [63:0] exp);
        logic [63:0] r;
        @(negedge i_clk_sys) cs_n = 1'b0;
        for (int b = 63; b >= 0; b--) begin
            @(negedge i_clk_sys) {sck, mosi} = {1'b1, w[b]};
            @(negedge i_clk_sys) {sck, r[b]} = {1'b0, o_serial_out};
        end
        repeat (5) @(negedge i_clk_sys) cs_n = 1'b1;
        chk("spi_out", r, exp);
    endtask : spi

    task automatic drain;
        for (int w = 0; w < 300 && (tx_q.size() + exec_q.size()) > 0; w++) @(negedge i_clk_sys);
        if ((tx_q.size() + exec_q.size()) > 0) begin
            errors++;
            end_of_test();
        end
    endtask : drain

    // --------
    // Result watcher
    // --------
    always @(posedge i_clk_sys) begin
        if (o_exec_valid) begin
            if (exec_q.size() == 0) chk("exec_unexpected", 64'h1, 64'h0);
            else chk("exec", {2'h0, cyc, o_exec_addr, o_exec_data}, exec_q.pop_front());
        end
        if (o_tx_valid[0] && i_tx_ready[0]) begin
            if (tx_q.size() == 0) chk("tx_unexpected", 64'h1, 64'h0);
            else chk("tx", pj(o_tx_msg), tx_q.pop_front());
        end
        if (o_resp_frame_error) chk("frame_err", 64'h1, 64'h0);
        cyc <= cyc + 1;
    end

    initial begin
        {cs_n, sck, mosi, i_deep_sleep, i_bus_activity, i_bus_busy, slow, i_reset_n} = 8'h80;
        {i_rx_valid, i_rx_ok, i_rx_msg} = '0;
        i_relay_enable = 1'b1;
        i_chain_node_count = 6'h08;
        repeat (10) @(negedge i_clk_sys);
        i_reset_n = 1'b1;
        chk("addr_reset", o_own_node_address, NODE_ADDR_RESET);
        send(0, CMD_WRITE, 1'b0, 6'h00, ADDR_ASSIGN_REG, 16'h0005);
        exec_q.push_back({2'h0, d + 1, ADDR_ASSIGN_REG, 16'h0005});
        send(0, CMD_WRITE, 1'b0, 6'h09, 14'h0020, 16'h1234);
        repeat (3) @(negedge i_clk_sys);
        chk("addr_set", o_own_node_address, 6'h05);
        $display("addressing done");
        for (int i = 0; i < 3; i++) begin
            i_chain_node_count = cnts[i];
            dat = 16'($random(seed));
            send(0, CMD_WRITE, dirs[i], TARGET_ALL, 14'h0030, dat);
            exec_q.push_back({2'h0, d + steps[i] * STEP + 3, 14'h0030, dat});
            repeat (steps[i] * STEP + 4) @(negedge i_clk_sys);
        end
        drain();
        $display("broadcast delay done");
        slow = 1'b1;
        for (int k = 0; k < 2; k++) begin
            a = 14'(16 + k);
            tx_q.push_back({CMD_RESPONSE, 3'h5, 6'h05, a, {2'h0, a} ^ 16'h5A5A, 16'h0000});
        end
        send(0, CMD_READ, 1'b0, 6'h05, 14'h0010, 16'h0002);
        repeat (6) @(negedge i_clk_sys) i_bus_busy = 1'($random(seed));
        i_bus_busy = 1'b0;
        drain();
        send(1, CMD_READ, 1'b0, TARGET_ALL, 14'h0010, 16'h0001);
        repeat (8) @(negedge i_clk_sys);
        $display("read responses done");
        spi({CMD_READ, 10'h145, 6'h00, 14'h0040, 16'h0002, 16'h0000}, 64'h0);
        for (int k = 64; k < 67; k++) begin
            a = 14'(k);
            spi({CMD_NOP, 10'h145, 52'h0}, (k < 66) ?
                {CMD_RESPONSE, 10'h145, 6'h00, a, {2'h0, a} ^ 16'h5A5A, 16'h0000} : 64'h0);
        end
        $display("spi done");
        i_deep_sleep = 1'b1;
        @(negedge i_clk_sys);
        i_deep_sleep = 1'b0;
        chk("addr_sleep", o_own_node_address, NODE_ADDR_RESET);
        chk("asleep", o_active, 1'b0);
        i_bus_activity = 1'b1;
        @(negedge i_clk_sys);
        i_bus_activity = 1'b0;
        chk("active", o_active, 1'b1);
        $display("sleep done");
        end_of_test();
    end
endmodule : test_daisy_chain_host_comm_node
